//--- ods_pkg.sv
// Shared constants, fields and types of the output data serializer
package ods_pkg;

  // ******************************
  // Register addresses
  // ******************************
  localparam logic [7:0] ADDR_CTRL      = 8'hA9;
  localparam logic [7:0] ADDR_TIMING    = 8'hAA;
  localparam logic [7:0] ADDR_DATA      = 8'hAB;
  localparam logic [7:0] ADDR_RATE_LO   = 8'hAC;
  localparam logic [7:0] ADDR_RATE_HI   = 8'hAD;
  localparam logic [7:0] ADDR_WARM1     = 8'hAE;
  localparam logic [7:0] ADDR_WARM2     = 8'hAF;
  localparam logic [7:0] ADDR_AMP_LEVEL = 8'hCE;

  // ******************************
  // Reset values and timing units
  // ******************************
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [3:0] EDGE_STEPS = 4'h8;
  localparam int         DIV_SHIFT  = 2;
  localparam int         OSC_SHIFT  = 6;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [1:0] {
    END_STOP   = 2'h0,
    END_REPEAT = 2'h1,
    END_ZEROS  = 2'h2,
    END_ONES   = 2'h3
  } end_code_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_WARM = 2'h1,
    S_SEND = 2'h3
  } state_t;

  typedef struct packed {
    end_code_t endCode;
    logic      forceDeviation;
    logic      modulationSelect;
    logic      forceOscillatorOn;
    logic      forceDividerOn;
    logic      forceAmplifierOn;
    logic      enable;
  } ctrl_t;

  typedef struct packed {
    logic [2:0] groupWidth;
    logic [1:0] edgeTime;
    logic [2:0] clockDivide;
  } timing_t;

  typedef struct packed {
    logic [3:0] dividerWarmupTime;
    logic [3:0] amplifierWarmupTime;
  } warm_t;

  typedef struct packed {
    logic oscillator;
    logic divider;
    logic amplifier;
  } power_t;

endpackage

//--- ods_fifo.sv
// Symbol group FIFO between the data register and the shifter
`timescale 1ns/1ps
module ods_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rdPtr, next_rdPtr, wrPtr, next_wrPtr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady && !flush;
  assign pop      = outReady && outValid && !flush;

  always_comb begin
    next_rdPtr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
    next_wrPtr = push ? AW'(wrPtr + 1'b1) : wrPtr;
    next_count = count;
    if (flush) begin
      next_rdPtr = '0;
      next_wrPtr = '0;
      next_count = '0;
    end else if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else begin
      rdPtr <= next_rdPtr;
      wrPtr <= next_wrPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  full_refuses_a : assert property (@(posedge clk) disable iff (sys_rst)
    (count == (AW+1)'(DEPTH)) |-> !inReady ##1 count == (AW+1)'(DEPTH) || $past(pop) || $past(flush))
    else $error("FIFO accepted data while full");
endmodule

//--- ods_edge_ramp.sv
// Amplifier edge ramp, one slice step per edge-time period
`timescale 1ns/1ps
module ods_edge_ramp (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       target,
  input  wire logic       shape,
  input  wire logic [1:0] edgeTime,
  output logic      [3:0] level
);
  logic [1:0] stepCnt, next_stepCnt;
  logic [3:0] next_level;

  always_comb begin
    next_level   = level;
    next_stepCnt = stepCnt;
    if (!shape) begin
      next_level   = target ? ods_pkg::EDGE_STEPS : 4'h0;
      next_stepCnt = 2'h0;
    end else if (tick) begin
      if (stepCnt >= edgeTime) begin
        next_stepCnt = 2'h0;
        if (target && level < ods_pkg::EDGE_STEPS) begin
          next_level = 4'(level + 4'h1);
        end else if (!target && level != 4'h0) begin
          next_level = 4'(level - 4'h1);
        end
      end else begin
        next_stepCnt = 2'(stepCnt + 2'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level   <= 4'h0;
      stepCnt <= 2'h0;
    end else begin
      level   <= next_level;
      stepCnt <= next_stepCnt;
    end
  end

  ramp_single_step_a : assert property (@(posedge clk) disable iff (sys_rst)
    $past(shape) && shape |-> level == $past(level) || level == 4'($past(level) + 4'h1)
      || level == 4'($past(level) - 4'h1))
    else $error("Edge ramp jumped more than one step");
endmodule

//--- rf_output_data_serializer.sv
// Output data serializer: registers, sequencer, shifter and drive outputs
// What this block does
// - Out of data: stop, repeat, zeros or ones
// - Force bit holds oscillator at deviation
// - Mode bit selects on-off or frequency keying
// - Test bits force oscillator and divider on
// - Force amplifier on, slice count passes through
// - Enable bit switches serializer, resets to zero
// - Group width is field value plus one
// - New width applies from the next group
// - Edge lasts eight ticks times edge field+1
// - Serializer tick is clock divided by field+1
// - Power enables only on while needed
// - Handshake and holding stage for next group
// - Deviation bus follows symbols in frequency mode
// - Amplifier slices ramp over the edge time
// - Data write clears empty, pulses once, LSB first
// - Symbol rate set by rate field and divider
// - Warm-up counted in 1, 4, 64 ticks
// - Edge shaping only in on-off keying
`timescale 1ns/1ps
module rf_output_data_serializer #(
  parameter logic [6:0] DEVIATION_CODE = 7'h40,
  parameter int         FIFO_DEPTH     = 16
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic     [7:0] sfrAddr,
  input  wire logic           sfrWrite,
  input  wire logic     [7:0] sfrWdata,
  output logic          [7:0] sfrRdata,
  output logic                groupEmpty,
  output logic                spaceAvail,
  output ods_pkg::power_t     powerEnable,
  output logic          [4:0] amplifierSliceCount,
  output logic          [6:0] deviation,
  output logic                symbolOut
);

  // ********************************
  // Register file
  // ********************************
  ods_pkg::ctrl_t   ctrl, next_ctrl;
  ods_pkg::timing_t timing, next_timing;
  ods_pkg::warm_t   warm1, next_warm1;
  logic [7:0] dataHold, next_dataHold;
  logic [7:0] rateLo, next_rateLo;
  logic [6:0] rateHi, next_rateHi;
  logic [3:0] oscWarm, next_oscWarm;
  logic [7:0] ampLevel, next_ampLevel;
  logic [7:0] next_sfrRdata;
  logic       wrPulse, next_wrPulse;
  logic       next_groupEmpty, next_spaceAvail;
  logic       dataWrite;
  logic       fifoInReady, fifoValid, fifoPop;
  logic [7:0] fifoData;

  assign dataWrite = sfrWrite && sfrAddr == ods_pkg::ADDR_DATA;

  always_comb begin
    next_ctrl     = ctrl;
    next_timing   = timing;
    next_warm1    = warm1;
    next_dataHold = dataHold;
    next_rateLo   = rateLo;
    next_rateHi   = rateHi;
    next_oscWarm  = oscWarm;
    next_ampLevel = ampLevel;
    next_wrPulse  = dataWrite;
    if (sfrWrite) begin
      case (sfrAddr)
        ods_pkg::ADDR_CTRL:      next_ctrl = ods_pkg::ctrl_t'(sfrWdata);
        ods_pkg::ADDR_TIMING:    next_timing = ods_pkg::timing_t'(sfrWdata);
        ods_pkg::ADDR_DATA:      next_dataHold = sfrWdata;
        ods_pkg::ADDR_RATE_LO:   next_rateLo = sfrWdata;
        ods_pkg::ADDR_RATE_HI:   next_rateHi = sfrWdata[6:0];
        ods_pkg::ADDR_WARM1:     next_warm1 = ods_pkg::warm_t'(sfrWdata);
        ods_pkg::ADDR_WARM2:     next_oscWarm = sfrWdata[3:0];
        ods_pkg::ADDR_AMP_LEVEL: next_ampLevel = sfrWdata;
        default: ;
      endcase
    end
    case (sfrAddr)
      ods_pkg::ADDR_CTRL:      next_sfrRdata = ctrl;
      ods_pkg::ADDR_TIMING:    next_sfrRdata = timing;
      ods_pkg::ADDR_DATA:      next_sfrRdata = dataHold;
      ods_pkg::ADDR_RATE_LO:   next_sfrRdata = rateLo;
      ods_pkg::ADDR_RATE_HI:   next_sfrRdata = {1'b0, rateHi};
      ods_pkg::ADDR_WARM1:     next_sfrRdata = warm1;
      ods_pkg::ADDR_WARM2:     next_sfrRdata = {4'h0, oscWarm};
      ods_pkg::ADDR_AMP_LEVEL: next_sfrRdata = ampLevel;
      default:                 next_sfrRdata = 8'h00;
    endcase
    next_groupEmpty = !(fifoValid || wrPulse || dataWrite);
    next_spaceAvail = fifoInReady && !wrPulse && !dataWrite;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl       <= ods_pkg::ctrl_t'(ods_pkg::CTRL_RST);
      timing     <= ods_pkg::timing_t'(ods_pkg::TIMING_RST);
      warm1      <= ods_pkg::warm_t'(ods_pkg::REG_RST);
      dataHold   <= ods_pkg::REG_RST;
      rateLo     <= ods_pkg::REG_RST;
      rateHi     <= ods_pkg::REG_RST[6:0];
      oscWarm    <= ods_pkg::REG_RST[3:0];
      ampLevel   <= ods_pkg::REG_RST;
      sfrRdata   <= 8'h00;
      wrPulse    <= 1'b0;
      groupEmpty <= 1'b1;
      spaceAvail <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      timing     <= next_timing;
      warm1      <= next_warm1;
      dataHold   <= next_dataHold;
      rateLo     <= next_rateLo;
      rateHi     <= next_rateHi;
      oscWarm    <= next_oscWarm;
      ampLevel   <= next_ampLevel;
      sfrRdata   <= next_sfrRdata;
      wrPulse    <= next_wrPulse;
      groupEmpty <= next_groupEmpty;
      spaceAvail <= next_spaceAvail;
    end
  end

  // ********************************
  // Group FIFO
  // ********************************
  ods_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .flush    (!ctrl.enable),
    .inValid  (wrPulse),
    .inReady  (fifoInReady),
    .inData   (dataHold),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // ********************************
  // Sequencer and shifter
  // ********************************
  ods_pkg::state_t state, next_state;
  logic [2:0]  divCnt, next_divCnt;
  logic [14:0] rateCnt, next_rateCnt;
  logic [9:0]  warmCnt, next_warmCnt;
  logic [7:0]  shiftReg, next_shiftReg;
  logic [7:0]  lastGroup, next_lastGroup;
  logic [2:0]  symIdx, next_symIdx;
  logic [2:0]  groupWidth, next_groupWidth;
  logic        sym, next_sym;
  logic        tick, symStrobe, reload;
  logic [14:0] rate, rateMax;
  logic [9:0]  oscT, divT, ampT, warmTotal;
  logic [7:0]  grp;

  assign tick    = divCnt >= timing.clockDivide;
  assign rate    = {rateHi, rateLo};
  assign rateMax = (rate == 15'h0000) ? 15'h0000 : 15'(rate - 15'h0001);
  assign symStrobe = tick && rateCnt >= rateMax;
  assign oscT = {oscWarm, 6'h00};
  assign divT = {4'h0, warm1.dividerWarmupTime, 2'h0};
  assign ampT = {6'h00, warm1.amplifierWarmupTime};
  assign warmTotal = (oscT >= divT && oscT >= ampT) ? oscT : (divT >= ampT) ? divT : ampT;

  always_comb begin
    next_state      = state;
    next_divCnt     = tick ? 3'h0 : 3'(divCnt + 3'h1);
    next_rateCnt    = rateCnt;
    next_warmCnt    = warmCnt;
    next_shiftReg   = shiftReg;
    next_lastGroup  = lastGroup;
    next_symIdx     = symIdx;
    next_groupWidth = groupWidth;
    next_sym        = sym;
    fifoPop         = 1'b0;
    reload          = 1'b0;
    grp             = 8'h00;
    case (state)
      ods_pkg::S_IDLE: begin
        next_rateCnt = 15'h0000;
        if (ctrl.enable && fifoValid) begin
          next_warmCnt = warmTotal;
          next_state   = ods_pkg::S_WARM;
        end
      end
      ods_pkg::S_WARM: begin
        if (tick) begin
          if (warmCnt == 10'h000) begin
            reload     = 1'b1;
            next_state = ods_pkg::S_SEND;
          end else begin
            next_warmCnt = 10'(warmCnt - 10'h001);
          end
        end
      end
      ods_pkg::S_SEND: begin
        if (tick) begin
          next_rateCnt = symStrobe ? 15'h0000 : 15'(rateCnt + 15'h0001);
        end
        if (symStrobe) begin
          if (symIdx == groupWidth) begin
            reload = 1'b1;
          end else begin
            next_sym      = shiftReg[0];
            next_shiftReg = {1'b0, shiftReg[7:1]};
            next_symIdx   = 3'(symIdx + 3'h1);
          end
        end
      end
      default: next_state = ods_pkg::S_IDLE;
    endcase
    if (reload) begin
      next_groupWidth = timing.groupWidth;
      if (fifoValid) begin
        fifoPop        = 1'b1;
        grp            = fifoData;
        next_lastGroup = fifoData;
      end else begin
        case (ctrl.endCode)
          ods_pkg::END_REPEAT: grp = lastGroup;
          ods_pkg::END_ZEROS:  grp = 8'h00;
          ods_pkg::END_ONES:   grp = 8'hFF;
          default:             next_state = ods_pkg::S_IDLE;
        endcase
      end
      next_sym      = grp[0];
      next_shiftReg = {1'b0, grp[7:1]};
      next_symIdx   = 3'h0;
    end
    if (!ctrl.enable) begin
      next_state = ods_pkg::S_IDLE;
      fifoPop    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= ods_pkg::S_IDLE;
      divCnt     <= 3'h0;
      rateCnt    <= 15'h0000;
      warmCnt    <= 10'h000;
      shiftReg   <= 8'h00;
      lastGroup  <= 8'h00;
      symIdx     <= 3'h0;
      groupWidth <= 3'h0;
      sym        <= 1'b0;
    end else begin
      state      <= next_state;
      divCnt     <= next_divCnt;
      rateCnt    <= next_rateCnt;
      warmCnt    <= next_warmCnt;
      shiftReg   <= next_shiftReg;
      lastGroup  <= next_lastGroup;
      symIdx     <= next_symIdx;
      groupWidth <= next_groupWidth;
      sym        <= next_sym;
    end
  end

  // ********************************
  // Drive outputs
  // ********************************
  ods_pkg::power_t next_power;
  logic [3:0] rampLevel;
  logic [8:0] rampProduct;
  logic [4:0] next_slices;
  logic [6:0] next_deviation;
  logic       sending, next_symbolOut;

  assign sending = ctrl.enable && state == ods_pkg::S_SEND;

  ods_edge_ramp u_ramp (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (tick),
    .target   (sending && (sym || ctrl.modulationSelect)),
    .shape    (!ctrl.modulationSelect),
    .edgeTime (timing.edgeTime),
    .level    (rampLevel)
  );

  assign rampProduct = ampLevel[7:3] * rampLevel;

  always_comb begin
    next_power.oscillator = ctrl.forceOscillatorOn
      || (ctrl.enable && state != ods_pkg::S_IDLE);
    next_power.divider = ctrl.forceDividerOn || sending
      || (ctrl.enable && state == ods_pkg::S_WARM && warmCnt <= divT);
    next_power.amplifier = ctrl.forceAmplifierOn || sending
      || (ctrl.enable && state == ods_pkg::S_WARM && warmCnt <= ampT);
    next_slices = ctrl.forceAmplifierOn ? ampLevel[7:3] : rampProduct[7:3];
    next_deviation = 7'h00;
    if (ctrl.forceDeviation) begin
      next_deviation = DEVIATION_CODE;
    end else if (sending && ctrl.modulationSelect && sym) begin
      next_deviation = DEVIATION_CODE;
    end
    next_symbolOut = sending && sym;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerEnable         <= '0;
      amplifierSliceCount <= 5'h00;
      deviation           <= 7'h00;
      symbolOut           <= 1'b0;
    end else begin
      powerEnable         <= next_power;
      amplifierSliceCount <= next_slices;
      deviation           <= next_deviation;
      symbolOut           <= next_symbolOut;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  idle_power_off_a : assert property (
    !ctrl.enable && ctrl == $past(ctrl) && !ctrl.forceOscillatorOn && !ctrl.forceDividerOn
      |=> !powerEnable.oscillator && !powerEnable.divider)
    else $error("Power enable active while disabled");

  force_osc_div_a : assert property (
    ctrl.forceOscillatorOn && ctrl.forceDividerOn |=> powerEnable.oscillator && powerEnable.divider)
    else $error("Forced enable not driven");

  force_amp_pass_a : assert property (
    ctrl.forceAmplifierOn |=> powerEnable.amplifier && amplifierSliceCount == $past(ampLevel[7:3]))
    else $error("Forced amplifier slices not passed through");

  force_dev_hold_a : assert property (
    ctrl.forceDeviation |=> deviation == DEVIATION_CODE)
    else $error("Forced deviation not held");

  data_write_pulse_a : assert property (
    dataWrite |=> wrPulse && !groupEmpty ##1 !wrPulse || $past(dataWrite))
    else $error("Data write did not pulse once or clear empty");

  fsk_deviation_a : assert property (
    sending && ctrl.modulationSelect && !ctrl.forceDeviation
      |=> deviation == ($past(sym) ? DEVIATION_CODE : 7'h00))
    else $error("Deviation does not follow symbol");

  end_stop_idle_a : assert property (
    sending && reload && !fifoValid && ctrl.endCode == ods_pkg::END_STOP
      |=> state == ods_pkg::S_IDLE ##1 !powerEnable.divider || ctrl.forceDividerOn)
    else $error("Stop code did not shut down");

  width_latch_a : assert property (
    reload && ctrl.enable |=> groupWidth == $past(timing.groupWidth) && symIdx == 3'h0)
    else $error("Group width not taken at group load");

  tick_spacing_a : assert property (
    tick && timing.clockDivide != 3'h0 ##1 $stable(timing) |-> !tick)
    else $error("Serializer tick faster than divide setting");

endmodule

//--- rf_far_side.sv
// Behavioural amplifier, divider and oscillator at the serializer outputs
`timescale 1ns/1ps
module rf_far_side (
  input  wire ods_pkg::power_t powerEnable,
  input  wire logic [4:0]      amplifierSliceCount,
  input  wire logic [6:0]      deviation,
  output logic                 radiating,
  output logic                 offsetOn
);
  // ******************************
  // Carrier and frequency offset
  // ******************************
  // Carrier only with the whole chain powered and slices on
  assign radiating = powerEnable.oscillator & powerEnable.divider & powerEnable.amplifier
                     & (amplifierSliceCount != 5'h00);
  assign offsetOn  = (deviation != 7'h00);
endmodule

//--- rf_output_data_serializer_tb.sv
// Testbench of the output data serializer
`timescale 1ns/1ps
module rf_output_data_serializer_tb;
  localparam logic [6:0] DEV = 7'h40;
  logic            clk;
  logic            sys_rst;
  logic [7:0]      sfrAddr;
  logic            sfrWrite;
  logic [7:0]      sfrWdata;
  logic [7:0]      sfrRdata;
  logic            groupEmpty;
  logic            spaceAvail;
  ods_pkg::power_t powerEnable;
  logic [4:0]      amplifierSliceCount;
  logic [6:0]      deviation;
  logic            symbolOut;
  logic            radiating;
  logic            offsetOn;
  int              fails;
  int              check_count;
  int              n;

  // ******************************
  // Design and far side
  // ******************************
  rf_output_data_serializer #(.DEVIATION_CODE(DEV), .FIFO_DEPTH(16)) dut (
    .clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .groupEmpty(groupEmpty),
    .spaceAvail(spaceAvail), .powerEnable(powerEnable),
    .amplifierSliceCount(amplifierSliceCount), .deviation(deviation), .symbolOut(symbolOut)
  );
  rf_far_side far (
    .powerEnable(powerEnable), .amplifierSliceCount(amplifierSliceCount),
    .deviation(deviation), .radiating(radiating), .offsetOn(offsetOn)
  );

  // ******************************
  // Tasks
  // ******************************
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    sfrAddr = a;
    @(negedge clk);
    chk("sfrRdata", 16'(e), 16'(sfrRdata));
  endtask

  task automatic wait1(int lim);
    int k;
    k = 0;
    while (symbolOut !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("symbolStart", 16'h0001, 16'(symbolOut));
  endtask

  // Samples each symbol in its middle, first symbol already showing
  task automatic syms(int per, int k, logic [15:0] pat, logic fsk);
    repeat (per / 2) @(negedge clk);
    for (int i = 0; i < k; i++) begin
      chk("symbolOut", 16'(pat[i]), 16'(symbolOut));
      if (fsk) chk("deviation", pat[i] ? 16'(DEV) : 16'h0000, 16'(deviation));
      repeat (per) @(negedge clk);
    end
  endtask

  task automatic stop_run;
    wr(ods_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(negedge clk);
    chk("powerEnable", 16'h0000, 16'(powerEnable));
    chk("groupEmpty", 16'h0001, 16'(groupEmpty));
    chk("symbolOut", 16'h0000, 16'(symbolOut));
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ******************************
  // Clock, reset and watchdog
  // ******************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_of_test;
  end

  // ******************************
  // Tests
  // ******************************
  initial begin
    fails = 0;
    check_count = 0;
    sys_rst = 1'b1;
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrWdata = 8'h00;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    // Reset values, reserved bits, unmapped address
    rd(ods_pkg::ADDR_CTRL, 8'h00);
    rd(ods_pkg::ADDR_TIMING, 8'h00);
    wr(ods_pkg::ADDR_RATE_HI, 8'hFF);
    rd(ods_pkg::ADDR_RATE_HI, 8'h7F);
    wr(ods_pkg::ADDR_WARM2, 8'hFF);
    rd(ods_pkg::ADDR_WARM2, 8'h0F);
    rd(8'hB0, 8'h00);
    chk("powerEnable", 16'h0000, 16'(powerEnable));
    wr(ods_pkg::ADDR_RATE_HI, 8'h00);
    wr(ods_pkg::ADDR_WARM2, 8'h00);
    // Force bits while disabled
    wr(ods_pkg::ADDR_AMP_LEVEL, 8'hAD);
    for (int i = 0; i < 3; i++) begin
      wr(ods_pkg::ADDR_CTRL, 8'h08 >> i);
      repeat (2) @(negedge clk);
      chk("powerEnable", 16'(3'b100 >> i), 16'(powerEnable));
    end
    chk("slices", 16'h0015, 16'(amplifierSliceCount));
    wr(ods_pkg::ADDR_CTRL, 8'h20);
    repeat (2) @(negedge clk);
    chk("offsetOn", 16'h0001, 16'(offsetOn));
    wr(ods_pkg::ADDR_DATA, 8'h55);
    stop_run;
    chk("deviation", 16'h0000, 16'(deviation));
    // On-off keying, width change between groups, stop code
    wr(ods_pkg::ADDR_RATE_LO, 8'h03);
    wr(ods_pkg::ADDR_TIMING, 8'hE1);
    wr(ods_pkg::ADDR_CTRL, 8'h01);
    wr(ods_pkg::ADDR_DATA, 8'hA5);
    repeat (3) @(negedge clk);
    wr(ods_pkg::ADDR_TIMING, 8'h21);
    wr(ods_pkg::ADDR_DATA, 8'h02);
    wait1(200);
    chk("powerEnable", 16'h0007, 16'(powerEnable));
    syms(6, 10, 16'h02A5, 1'b0);
    n = 0;
    while (powerEnable !== 3'b000 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("powerEnable", 16'h0000, 16'(powerEnable));
    // Zeros code keeps the chain up
    wr(ods_pkg::ADDR_TIMING, 8'h20);
    wr(ods_pkg::ADDR_CTRL, 8'h81);
    wr(ods_pkg::ADDR_DATA, 8'h01);
    wait1(200);
    syms(3, 5, 16'h0001, 1'b0);
    chk("oscillator", 16'h0001, 16'(powerEnable.oscillator));
    stop_run;
    // Ones code and the amplifier ramp
    wr(ods_pkg::ADDR_TIMING, 8'hE8);
    wr(ods_pkg::ADDR_CTRL, 8'hC1);
    wr(ods_pkg::ADDR_DATA, 8'hFF);
    n = 0;
    while (amplifierSliceCount === 5'h00 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (amplifierSliceCount !== 5'h15 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("rampClocks", 16'h0001, 16'(n >= 13 && n <= 15));
    chk("radiating", 16'h0001, 16'(radiating));
    stop_run;
    // Frequency keying with repeat code
    wr(ods_pkg::ADDR_TIMING, 8'h28);
    wr(ods_pkg::ADDR_CTRL, 8'h51);
    wr(ods_pkg::ADDR_DATA, 8'h01);
    wait1(200);
    syms(3, 6, 16'h0015, 1'b1);
    chk("slices", 16'h0015, 16'(amplifierSliceCount));
    chk("powerEnable", 16'h0007, 16'(powerEnable));
    stop_run;
    // Fill the buffer during a long warm-up, then drain it
    wr(ods_pkg::ADDR_WARM2, 8'h0F);
    wr(ods_pkg::ADDR_TIMING, 8'hFF);
    wr(ods_pkg::ADDR_RATE_LO, 8'h01);
    wr(ods_pkg::ADDR_CTRL, 8'h01);
    n = 0;
    for (int i = 0; i < 45; i++) begin
      @(negedge clk);
      if (spaceAvail === 1'b1) begin
        wr(ods_pkg::ADDR_DATA, 8'(i));
        n++;
      end
    end
    chk("accepted", 16'h0001, 16'(n == 16 || n == 17));
    chk("groupEmpty", 16'h0000, 16'(groupEmpty));
    chk("powerEnable", 16'h0004, 16'(powerEnable));
    n = 0;
    while (groupEmpty !== 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    chk("groupEmpty", 16'h0001, 16'(groupEmpty));
    chk("spaceAvail", 16'h0001, 16'(spaceAvail));
    stop_run;
    end_of_test;
  end
endmodule
